// file: common/jt_pkg.sv
// Shared constants and types of the boundary-scan pattern engine and its controller
`default_nettype none
package jt_pkg;
   // TAP controller states
   typedef enum logic [3:0] {
      TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
      TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
      TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR  = 4'hb,
      TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
   } jt_tap_e;

   // Test operations held in all three bits of the test control register
   typedef enum logic [2:0] {
      MODE_TOGGLE = 3'h0,
      MODE_PATGEN = 3'h1,
      MODE_SIGCMP = 3'h2,
      MODE_SIGPAT = 3'h3,
      MODE_SIGCNT = 3'h7
   } jt_mode_e;

   // Instruction register
   localparam logic [7:0] IR_CAPTURE    = 8'h81;
   localparam logic [7:0] IR_BYPASS     = 8'hff;
   localparam logic [7:0] OP_CHAIN_SCAN = 8'h00;
   localparam logic [7:0] OP_CTL_SCAN   = 8'h0f;
   localparam logic [7:0] OP_RUN_TEST   = 8'h0a;

   // Boundary chain layout
   localparam int         CHAIN_W = 48;
   localparam int         AB_EN1  = 47;
   localparam int         AB_EN2  = 46;
   localparam int         BA_EN1  = 45;
   localparam int         BA_EN2  = 44;
   localparam logic [47:0] SH_RST = 48'hf000_0000_0000;

   // Default maximal-length feedback: x^36+x^25+1 and x^18+x^11+1
   localparam logic [35:0] TAPS36_DEF = 36'h8_0100_0000;
   localparam logic [17:0] TAPS18_DEF = 18'h2_0400;

   // Clock and link timing
   localparam int CLK_NS       = 25;
   localparam int TCK_NS       = 200;
   localparam int TCK_HALF_CYC = TCK_NS / (2 * CLK_NS);

   // Controller register map and responses
   localparam logic [7:0] REG_TMS  = 8'h00;
   localparam logic [7:0] REG_TDI  = 8'h04;
   localparam logic [7:0] REG_CMD  = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_TDO  = 8'h10;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : jt_pkg
`default_nettype wire

// file: common/jt_if.sv
// Four-wire test access link between controller and device
`timescale 1ns/100ps
`default_nettype none
interface jt_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic tdo_line;

   // Undriven serial output reads high, as through a board pull-up
   assign tdo_line = tdo_oe ? tdo : 1'b1;

   modport host (output tck, output tms, output tdi, input tdo_line);
   modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface : jt_if
`default_nettype wire

// file: hw/jt_dev.sv
// Device end: TAP controller, boundary chain and run-test pattern engine
`timescale 1ns/100ps
`default_nettype none
module jt_dev
   import jt_pkg::*;
#(
   parameter logic [35:0] TAPS36_AB = TAPS36_DEF,
   parameter logic [35:0] TAPS36_BA = TAPS36_DEF,
   parameter logic [17:0] TAPS18_AB = TAPS18_DEF,
   parameter logic [17:0] TAPS18_BA = TAPS18_DEF
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   jt_if.dev                lnk,
   input  wire logic [17:0] a_in,
   input  wire logic [17:0] b_in,
   output logic      [17:0] a_out,
   output logic      [17:0] a_oe,
   output logic      [17:0] b_out,
   output logic      [17:0] b_oe
);
   // Feedback without the top tap would not be a full-width register
   if (!TAPS36_AB[35] || !TAPS36_BA[35] || !TAPS18_AB[17] || !TAPS18_BA[17])
   begin : g_bad_taps
      $error("jt_dev: top tap bit of every feedback mask must be set");
   end

   logic [38:0] s1_r;
   logic [38:0] s2_r;
   logic        tck_q_r;
   logic        rise;
   logic        fall;
   logic        tms_s;
   logic        tdi_s;
   logic [17:0] a_s;
   logic [17:0] b_s;

   // Two flip-flops on every pin before any logic looks at it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r    <= '0;
         s2_r    <= '0;
         tck_q_r <= 1'b0;
      end
      else
      begin
         s1_r    <= {lnk.tck, lnk.tms, lnk.tdi, a_in, b_in};
         s2_r    <= s1_r;
         tck_q_r <= s2_r[38];
      end
   end

   // Test clock edges; everything below moves only on these
   assign rise  = s2_r[38] & ~tck_q_r;
   assign fall  = ~s2_r[38] & tck_q_r;
   assign tms_s = s2_r[37];
   assign tdi_s = s2_r[36];
   assign a_s   = s2_r[35:18];
   assign b_s   = s2_r[17:0];

   function automatic jt_tap_e tap_next(input jt_tap_e s, input logic m);
      unique case (s)
         TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction : tap_next

   // Opcode X00 and 1XX overlap, so the low pair decides first
   function automatic jt_mode_e mode_of(input logic [2:0] c);
      unique case (c[1:0])
         2'h0:    mode_of = MODE_TOGGLE;
         2'h1:    mode_of = MODE_PATGEN;
         2'h2:    mode_of = MODE_SIGCMP;
         default: mode_of = c[2] ? MODE_SIGCNT : MODE_SIGPAT;
      endcase
   endfunction : mode_of

   // XOR feedback keeps an all-zero register at zero
   function automatic logic [35:0] step36(input logic [35:0] s, input logic [35:0] t);
      step36 = {s[34:0], ^(s & t)};
   endfunction : step36

   function automatic logic [17:0] step18(input logic [17:0] s, input logic [17:0] t);
      step18 = {s[16:0], ^(s & t)};
   endfunction : step18

   jt_tap_e     st_r,   st_nxt;
   logic [7:0]  irs_r,  irs_nxt;
   logic [7:0]  ir_r,   ir_nxt;
   logic [47:0] ch_r,   ch_nxt;
   logic [47:0] sh_r,   sh_nxt;
   logic [2:0]  ctl_r,  ctl_nxt;
   logic        byp_r,  byp_nxt;
   logic        tdo_r,  tdo_nxt;
   logic        toe_r,  toe_nxt;
   logic [17:0] ao_r,   ao_nxt;
   logic [17:0] aoe_r,  aoe_nxt;
   logic [17:0] bo_r,   bo_nxt;
   logic [17:0] boe_r,  boe_nxt;

   logic        ab;
   logic        ba;
   logic        run_go;
   logic        sel_ch;
   logic        sel_ctl;
   logic        tmode;
   jt_mode_e    mode;

   // Direction comes from the enable latches that drive the pins
   assign ab      = ~sh_r[AB_EN1] & ~sh_r[AB_EN2] & sh_r[BA_EN1] & sh_r[BA_EN2];
   assign ba      = sh_r[AB_EN1] & sh_r[AB_EN2] & ~sh_r[BA_EN1] & ~sh_r[BA_EN2];
   assign run_go  = (ir_r == OP_RUN_TEST) && (st_r == TAP_IDLE) && (ab || ba);
   assign sel_ch  = (ir_r == OP_CHAIN_SCAN);
   assign sel_ctl = (ir_r == OP_CTL_SCAN);
   assign tmode   = sel_ch || (ir_r == OP_RUN_TEST);
   assign mode    = mode_of(ctl_r);

   logic [35:0] io;
   logic [35:0] eng;
   logic [17:0] in_h;
   logic [17:0] out_h;
   logic [17:0] pin_h;
   logic [17:0] in_n;
   logic [17:0] out_n;
   logic [35:0] t36;
   logic [17:0] t18;

   // Next content of the I/O cells for one run-test clock
   always_comb
   begin
      io    = ch_r[35:0];
      t36   = ab ? TAPS36_AB : TAPS36_BA;
      t18   = ab ? TAPS18_AB : TAPS18_BA;
      in_h  = ab ? io[35:18] : io[17:0];
      out_h = ab ? io[17:0] : io[35:18];
      pin_h = ab ? a_s : b_s;
      in_n  = step18(in_h, t18) ^ pin_h;
      out_n = out_h;
      eng   = io;
      unique case (mode)
         MODE_TOGGLE:
         begin
            in_n  = pin_h;
            out_n = ~out_h;
         end
         MODE_PATGEN: eng   = step36(io, t36);
         MODE_SIGCMP: eng   = step36(io, t36) ^ (ab ? {a_s, 18'h0} : {18'h0, b_s});
         MODE_SIGPAT: out_n = step18(out_h, t18);
         MODE_SIGCNT: out_n = out_h + 18'h1;
      endcase
      if (mode != MODE_PATGEN && mode != MODE_SIGCMP)
      begin
         eng = ab ? {in_n, out_n} : {out_n, in_n};
      end
   end

   // TAP, instruction, data registers and shadow latches
   always_comb
   begin
      st_nxt  = st_r;
      irs_nxt = irs_r;
      ir_nxt  = ir_r;
      ch_nxt  = ch_r;
      sh_nxt  = sh_r;
      ctl_nxt = ctl_r;
      byp_nxt = byp_r;
      tdo_nxt = tdo_r;
      toe_nxt = toe_r;
      if (rise)
      begin
         st_nxt = tap_next(st_r, tms_s);
         unique case (st_r)
            TAP_CAP_IR: irs_nxt = IR_CAPTURE;
            TAP_SH_IR:  irs_nxt = {tdi_s, irs_r[7:1]};
            TAP_CAP_DR:
            begin
               byp_nxt = 1'b0;
               if (sel_ch)
               begin
                  ch_nxt[35:0] = {a_s, b_s};
               end
            end
            TAP_SH_DR:
            begin
               byp_nxt = tdi_s;
               if (sel_ch)
               begin
                  ch_nxt = {tdi_s, ch_r[47:1]};
               end
               if (sel_ctl)
               begin
                  ctl_nxt = {tdi_s, ctl_r[2:1]};
               end
            end
            TAP_IDLE:
            begin
               // Control cells 47..36 never take part in the algorithms
               if (run_go)
               begin
                  ch_nxt[35:0] = eng;
               end
            end
            default: ;
         endcase
      end
      if (fall)
      begin
         toe_nxt = (st_r == TAP_SH_IR) || (st_r == TAP_SH_DR);
         tdo_nxt = (st_r == TAP_SH_IR) ? irs_r[0] :
                   sel_ch ? ch_r[0] : sel_ctl ? ctl_r[0] : byp_r;
         unique case (st_r)
            TAP_RESET:  ir_nxt = IR_BYPASS;
            TAP_UPD_IR: ir_nxt = irs_r;
            TAP_UPD_DR:
            begin
               if (sel_ch)
               begin
                  sh_nxt = ch_r;
               end
            end
            TAP_IDLE:
            begin
               // Signature mode leaves the latches driving their old values
               if (run_go && mode != MODE_SIGCMP)
               begin
                  sh_nxt[35:0] = ch_r[35:0];
               end
            end
            default: ;
         endcase
      end
   end

   // Pins follow the latches; enable cells still steer drive in run mode
   always_comb
   begin
      ao_nxt  = sh_r[35:18];
      bo_nxt  = sh_r[17:0];
      aoe_nxt = tmode ? {{9{~sh_r[BA_EN2]}}, {9{~sh_r[BA_EN1]}}} : 18'h0;
      boe_nxt = tmode ? {{9{~sh_r[AB_EN2]}}, {9{~sh_r[AB_EN1]}}} : 18'h0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r  <= TAP_RESET;
         irs_r <= 8'h00;
         ir_r  <= IR_BYPASS;
         ch_r  <= SH_RST;
         sh_r  <= SH_RST;
         ctl_r <= 3'h0;
         byp_r <= 1'b0;
         tdo_r <= 1'b0;
         toe_r <= 1'b0;
         ao_r  <= 18'h0;
         aoe_r <= 18'h0;
         bo_r  <= 18'h0;
         boe_r <= 18'h0;
      end
      else
      begin
         st_r  <= st_nxt;
         irs_r <= irs_nxt;
         ir_r  <= ir_nxt;
         ch_r  <= ch_nxt;
         sh_r  <= sh_nxt;
         ctl_r <= ctl_nxt;
         byp_r <= byp_nxt;
         tdo_r <= tdo_nxt;
         toe_r <= toe_nxt;
         ao_r  <= ao_nxt;
         aoe_r <= aoe_nxt;
         bo_r  <= bo_nxt;
         boe_r <= boe_nxt;
      end
   end

   assign lnk.tdo    = tdo_r;
   assign lnk.tdo_oe = toe_r;
   assign a_out      = ao_r;
   assign a_oe       = aoe_r;
   assign b_out      = bo_r;
   assign b_oe       = boe_r;
endmodule : jt_dev
`default_nettype wire

// file: hw/jt_host.sv
// Controller end: AXI4-Lite command registers driving the test access link
`timescale 1ns/100ps
`default_nettype none
module jt_host
   import jt_pkg::*;
#(
   parameter int TCK_HALF = TCK_HALF_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   jt_if.host               lnk,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic      [1:0]  bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   // Serial output must settle through both synchronisers within a period
   if (TCK_HALF < 4 || TCK_HALF > 255)
   begin : g_bad_half
      $error("jt_host: TCK_HALF must lie in 4..255");
   end

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++)
      begin
         merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction : merge

   logic        tdo1_r;
   logic        tdo_s;
   logic        awr_r,  awr_nxt;
   logic        bv_r,   bv_nxt;
   logic [1:0]  br_r,   br_nxt;
   logic        arr_r,  arr_nxt;
   logic        rv_r,   rv_nxt;
   logic [1:0]  rr_r,   rr_nxt;
   logic [31:0] rd_r,   rd_nxt;
   logic [31:0] tmsv_r, tmsv_nxt;
   logic [31:0] tdiv_r, tdiv_nxt;
   logic [31:0] tdov_r, tdov_nxt;
   logic        busy_r, busy_nxt;
   logic [5:0]  len_r,  len_nxt;
   logic [5:0]  idx_r,  idx_nxt;
   logic [7:0]  cnt_r,  cnt_nxt;
   logic        tck_r,  tck_nxt;
   logic        tms_r,  tms_nxt;
   logic        tdi_r,  tdi_nxt;

   // Bus slave and shift sequencer share the vector registers
   always_comb
   begin
      awr_nxt  = awvalid & wvalid & ~awr_r & ~bv_r;
      bv_nxt   = bv_r & ~bready;
      br_nxt   = br_r;
      arr_nxt  = arvalid & ~arr_r & ~rv_r;
      rv_nxt   = rv_r & ~rready;
      rr_nxt   = rr_r;
      rd_nxt   = rd_r;
      tmsv_nxt = tmsv_r;
      tdiv_nxt = tdiv_r;
      tdov_nxt = tdov_r;
      busy_nxt = busy_r;
      len_nxt  = len_r;
      idx_nxt  = idx_r;
      cnt_nxt  = cnt_r;
      tck_nxt  = tck_r;
      tms_nxt  = tms_r;
      tdi_nxt  = tdi_r;
      if (arr_r)
      begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OK;
         unique case (araddr)
            REG_TMS:  rd_nxt = tmsv_r;
            REG_TDI:  rd_nxt = tdiv_r;
            REG_CMD:  rd_nxt = {26'h0, len_r};
            REG_STAT: rd_nxt = {31'h0, busy_r};
            REG_TDO:  rd_nxt = tdov_r;
            default:
            begin
               rd_nxt = 32'h0;
               rr_nxt = RESP_ERR;
            end
         endcase
      end
      if (busy_r)
      begin
         // Edges come from a divider; no second clock domain here
         if (cnt_r != 8'(TCK_HALF - 1))
         begin
            cnt_nxt = cnt_r + 8'h1;
         end
         else
         begin
            cnt_nxt = 8'h0;
            tck_nxt = ~tck_r;
            if (tck_r)
            begin
               // Falling edge: take the bit, then move mode and data lines
               tdov_nxt[idx_r[4:0]] = tdo_s;
               tmsv_nxt = {1'b0, tmsv_r[31:1]};
               tdiv_nxt = {1'b0, tdiv_r[31:1]};
               tms_nxt  = tmsv_r[1];
               tdi_nxt  = tdiv_r[1];
               idx_nxt  = idx_r + 6'h1;
               busy_nxt = (idx_r + 6'h1) != len_r;
            end
         end
      end
      if (awr_r)
      begin
         bv_nxt = 1'b1;
         br_nxt = RESP_OK;
         unique case (awaddr)
            REG_TMS:  tmsv_nxt = busy_r ? tmsv_r : merge(tmsv_r, wdata, wstrb);
            REG_TDI:  tdiv_nxt = busy_r ? tdiv_r : merge(tdiv_r, wdata, wstrb);
            REG_CMD:
            begin
               // Seed loads are plain shifts, started here by software
               if (!busy_r && wstrb[0] && wdata[5:0] != 6'h0 && wdata[5:0] <= 6'h20)
               begin
                  busy_nxt = 1'b1;
                  len_nxt  = wdata[5:0];
                  idx_nxt  = 6'h0;
                  cnt_nxt  = 8'h0;
                  tdov_nxt = 32'h0;
                  tms_nxt  = tmsv_r[0];
                  tdi_nxt  = tdiv_r[0];
               end
            end
            REG_STAT, REG_TDO: ;
            default:  br_nxt = RESP_ERR;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tdo1_r <= 1'b1;
         tdo_s  <= 1'b1;
         awr_r  <= 1'b0;
         bv_r   <= 1'b0;
         br_r   <= RESP_OK;
         arr_r  <= 1'b0;
         rv_r   <= 1'b0;
         rr_r   <= RESP_OK;
         rd_r   <= 32'h0;
         tmsv_r <= 32'h0;
         tdiv_r <= 32'h0;
         tdov_r <= 32'h0;
         busy_r <= 1'b0;
         len_r  <= 6'h0;
         idx_r  <= 6'h0;
         cnt_r  <= 8'h0;
         tck_r  <= 1'b0;
         tms_r  <= 1'b1;
         tdi_r  <= 1'b1;
      end
      else
      begin
         tdo1_r <= lnk.tdo_line;
         tdo_s  <= tdo1_r;
         awr_r  <= awr_nxt;
         bv_r   <= bv_nxt;
         br_r   <= br_nxt;
         arr_r  <= arr_nxt;
         rv_r   <= rv_nxt;
         rr_r   <= rr_nxt;
         rd_r   <= rd_nxt;
         tmsv_r <= tmsv_nxt;
         tdiv_r <= tdiv_nxt;
         tdov_r <= tdov_nxt;
         busy_r <= busy_nxt;
         len_r  <= len_nxt;
         idx_r  <= idx_nxt;
         cnt_r  <= cnt_nxt;
         tck_r  <= tck_nxt;
         tms_r  <= tms_nxt;
         tdi_r  <= tdi_nxt;
      end
   end

   assign awready = awr_r;
   assign wready  = awr_r;
   assign bvalid  = bv_r;
   assign bresp   = br_r;
   assign arready = arr_r;
   assign rvalid  = rv_r;
   assign rresp   = rr_r;
   assign rdata   = rd_r;
   assign lnk.tck = tck_r;
   assign lnk.tms = tms_r;
   assign lnk.tdi = tdi_r;
endmodule : jt_host
`default_nettype wire

// file: tb/jt_assertions.sv
// Timing checks on the test link between controller and device ends
`timescale 1ns/100ps
`default_nettype none
module jt_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Each tck high phase is four aclk long at the default divider, each low phase at least four
   sequence s_high;
      tck [*4] ##1 !tck;
   endsequence
   sequence s_low;
      !tck [*4];
   endsequence

   a_tck_high_len: assert property ($rose(tck) |-> s_high)
      else $error("tck high phase has wrong length");
   a_tck_low_len: assert property ($fell(tck) |-> s_low)
      else $error("tck low phase too short");
   a_tms_low_move: assert property ($changed(tms) |-> !tck)
      else $error("tms moved while tck high");
   a_tdi_low_move: assert property ($changed(tdi) |-> !tck)
      else $error("tdi moved while tck high");
   // Device reacts through synchronisers, so a change lags the fall
   a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
      else $error("tdo changed outside the low phase");
   a_oe_after_fall: assert property ($changed(tdo_oe) |-> !tck && !$past(tck))
      else $error("tdo enable changed outside the low phase");
   a_tdo_hold_high: assert property ($rose(tck) |-> $stable(tdo) [*4])
      else $error("tdo moved during the high phase");
   a_reset_idle: assert property ($rose(aresetn) |-> !tck && tms && !tdo_oe)
      else $error("link not idle after reset");
endmodule : jt_assertions
`default_nettype wire

// file: tb/tb_boundary_scan_pattern_engine.sv
// Self-checking bench: controller and device joined over the test link
`timescale 1ns/100ps
`default_nettype none
module tb_boundary_scan_pattern_engine;
   import jt_pkg::*;
   localparam int K = 5;   // Run-test steps per mode
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b1;
   logic        rready = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [17:0] a_out, a_oe, b_out, b_oe;
   logic [17:0] pins_a = 18'h2aaaa;
   logic [17:0] pins_b = 18'h15555;
   int          errors = 0;
   int          check_count = 0;
   int          cyc = 0;

   jt_if lnk ();
   jt_host jt_host_i (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   jt_dev jt_dev_i (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .a_in(pins_a), .b_in(pins_b),
      .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe));
   jt_assertions jt_assertions_i (.aclk(aclk), .aresetn(aresetn), .tck(lnk.tck), .tms(lnk.tms),
      .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe(lnk.tdo_oe));

   // Clock and watchdog; the ceiling is several times the expected run
   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         errors++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk_val

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
      chk_val(48'(got), 48'(exp), msg);
   endtask : chk_resp

   // Ready and response are both taken at the edge; bready stays high throughout
   task automatic axi_w(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
         begin
            awvalid <= 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid);
      r = bresp;
   endtask : axi_w

   task automatic axi_r(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : axi_r

   // One link burst of n bits; returns the sampled serial output
   task automatic sh(input logic [31:0] tm, input logic [31:0] td, input int n, output logic [31:0] q);
      logic [1:0] r;
      axi_w(REG_TMS, tm, r);
      axi_w(REG_TDI, td, r);
      axi_w(REG_CMD, 32'(n), r);
      do axi_r(REG_STAT, q, r); while (q[0] === 1'b1);
      axi_r(REG_TDO, q, r);
   endtask : sh

   // Idle to idle instruction scan
   task automatic ir(input logic [7:0] op, output logic [7:0] cap);
      logic [31:0] t;
      sh(32'h1803, {20'h0, op, 4'h0}, 14, t);
      cap = t[11:4];
   endtask : ir

   // Idle to idle data scan, split into bursts of at most 30 data bits
   task automatic dr(input logic [47:0] d, input int w, output logic [47:0] q);
      logic [31:0] t;
      int c;
      q = '0;
      sh(32'h1, 32'h0, 3, t);
      for (int i = 0; i < w; i += c)
      begin
         c = (w - i > 30) ? 30 : w - i;
         sh((i + c == w) ? 32'h3 << (c - 1) : 32'h0, 32'(d >> i), (i + c == w) ? c + 2 : c, t);
         q |= (48'(t) & ((48'h1 << c) - 48'h1)) << i;
      end
   endtask : dr

   // Load mode and seed, idle K clocks under run-test, compare both pin groups with a model
   task automatic run(input logic [2:0] m, input logic [3:0] en, input logic [35:0] s, input string nm);
      logic [7:0]  c;
      logic [47:0] q;
      logic [35:0] s36;
      logic [17:0] o18;
      logic [17:0] g18;
      logic [17:0] p18;
      logic [31:0] t;
      logic        ab;
      logic        go;
      ir(OP_CTL_SCAN, c);
      dr({45'h0, m}, 3, q);
      ir(OP_CHAIN_SCAN, c);
      dr({en, 8'h00, s}, 48, q);
      ir(OP_RUN_TEST, c);
      sh(32'h0, 32'h0, K, t);
      repeat (8) @(posedge aclk);
      // Output and input halves swap with the direction of flow
      ab  = (en == 4'b0011);
      go  = ab || (en == 4'b1100);
      s36 = s;
      o18 = ab ? s[17:0] : s[35:18];
      g18 = ab ? s[35:18] : s[17:0];
      p18 = ab ? pins_a : pins_b;
      for (int k = 0; k < K && go; k++)
      begin
         case (m[1:0])
            2'b00:
            begin
               o18 = ~o18;
               g18 = p18;
            end
            2'b01: s36 = {s36[34:0], ^(s36 & TAPS36_DEF)};
            2'b10: ;
            default:
            begin
               o18 = m[2] ? o18 + 18'h1 : {o18[16:0], ^(o18 & TAPS18_DEF)};
               g18 = {g18[16:0], ^(g18 & TAPS18_DEF)} ^ p18;
            end
         endcase
      end
      if (m[1:0] != 2'b01)
         s36 = ab ? {g18, o18} : {o18, g18};
      chk_val(48'(b_out), 48'(s36[17:0]), nm);
      chk_val(48'(a_out), 48'(s36[35:18]), {nm, " upper half"});
      if (go)
         chk_val(48'({a_oe, b_oe}), 48'({~{18{ab}}, {18{ab}}}), "drive enables");
      $display("test done: %s", nm);
   endtask : run

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  c;
      logic [47:0] q;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_r(REG_STAT, d, r);
      chk_val(48'(d), 48'h0, "idle status");
      chk_val(48'({a_oe, b_oe, lnk.tdo_oe}), 48'h0, "reset drive");
      axi_r(8'h40, d, r);
      chk_resp(r, RESP_ERR, "unmapped read");
      axi_w(8'h40, 32'h0, r);
      chk_resp(r, RESP_ERR, "unmapped write");
      $display("test done: registers");
      sh(32'h0, 32'h0, 1, d);
      ir(IR_BYPASS, c);
      chk_val(48'(c), 48'(IR_CAPTURE), "instruction capture");
      dr(48'h5, 3, q);
      chk_val(q, 48'h2, "bypass shift");
      chk_val(48'(lnk.tdo_oe), 48'h0, "serial out released");
      $display("test done: link");
      run(3'b001, 4'b0011, 36'h1_2345_6789, "pattern");
      run(3'b101, 4'b0011, 36'h0_0000_0000, "zero seed");
      run(3'b110, 4'b0011, 36'h0_00ab_cdef, "signature");
      run(3'b011, 4'b0011, 36'h0_0001_2345, "sig pattern");
      run(3'b111, 4'b0011, 36'h0_0003_fffe, "sig count");
      run(3'b000, 4'b0011, 36'h0_0002_5a5a, "toggle");
      run(3'b011, 4'b1100, 36'h2_4680_1357, "reverse sig pattern");
      run(3'b001, 4'b0110, 36'h1_2345_6789, "mixed bypass");
      results();
   end
endmodule : tb_boundary_scan_pattern_engine
`default_nettype wire
